// ### src/ufis_ctrl.v
// Flow control, infrared coding and sleep logic of a 16-byte FIFO UART
`timescale 1ns/1ns
`include "ufis_regs.vh"
// Operation
// - Auto RTS raises receive interrupt when FIFO fill reaches trigger level
// - Auto RTS drives RTS pin high at next trigger level above programmed
// - RTS returns low once FIFO drained to next level below programmed
// - Receiver keeps storing characters while RTS is high, until FIFO full
// - Auto CTS flow control active only while feature bit 7 set
// - CTS interrupt enable writable after feature bit 4; CTS high sets status bit 5
// - CTS high halts transmitter after current stop bit; resumes when low
// - Match one or two received characters against Xoff; halt transmit after character
// - Xoff match sets Xoff flag and interrupt when enable bit 5 set
// - After Xoff, matching Xon resumes transmit and clears status bit 4
// - Reset clears all four Xon/Xoff character registers
// - Consumed Xon/Xoff characters never enter the receive FIFO
// - Auto Xoff sent two character times after FIFO crosses trigger level
// - Xon sent when fill drops to one level under the trigger
// - Special character mode stores Xoff2 matches and sets status bit 4
// - Comparisons use only configured word length, bit 0 first received
// - Infrared encoder sends 3/16-bit high pulse for each zero bit
// - Infrared transmit idles low, receive idle low, receive polarity invertible
// - Sleep entered only when idle, divisor nonzero, enabled, deltas clear
// - Wake on start edge, holding write or CTS change; wake flag clears on read
// - Power isolate during sleep blocks bus writes; wakes only on start edge or CTS
module ufis_ctrl #(
  parameter FIFO_DEPTH = 16
) (
  input  wire        clk_sys,           // System clock
  input  wire        resetn,            // Async reset, active low
  input  wire        psel,              // APB select
  input  wire        penable,           // APB enable
  input  wire        pwrite,            // APB direction
  input  wire [7:0]  paddr,             // APB byte address
  input  wire [31:0] pwdata,            // APB write data
  output wire        pready,            // APB ready
  output reg  [31:0] prdata,            // APB read data
  output wire        pslverr,           // APB error on unmapped address
  input  wire        baud16_tick,       // 16x baud enable pulse
  input  wire [4:0]  rx_fill,           // Receive FIFO fill count
  input  wire        rx_char_vld,       // Received character strobe
  input  wire [7:0]  rx_char,           // Received character
  output wire        rx_store,          // Write strobe into receive FIFO
  input  wire        tx_bit_start,      // Start of each transmitted bit
  input  wire        tx_serial,         // Core serial data out
  input  wire        tx_fc_ack,         // Core took one flow char
  output wire        tx_hold,           // Stop at next character boundary
  output reg         tx_fc_req,         // Flow char send request
  output reg  [7:0]  tx_fc_char,        // Flow char to send
  output reg         txd_pin,           // Serial/IR transmit pin
  input  wire        rxd_pin,           // Serial/IR receive pin
  output reg         rx_serial,         // Decoded receive data to core
  output reg         rts_n_pin,         // RTS pin, active low
  input  wire        cts_n_pin,         // CTS pin, active low
  input  wire [3:1]  msr_delta_in,      // Other modem deltas from core
  input  wire        core_int_pend,     // Other core interrupts pending
  output wire        irq,               // Interrupt output
  output wire        rx_trig_int,       // Receive trigger interrupt
  input  wire        power_isolate_pin, // Power-save strap
  output reg         sleep_q,           // Sleep state
  output wire        bus_isolate        // Bus isolation active
);
// ****************************************
// Helpers
// ****************************************
  function [4:0] trig_lvl;
    input [2:0] idx;
    begin
      case (idx)
        3'd0:    trig_lvl = 5'd0;
        3'd1:    trig_lvl = 5'd1;
        3'd2:    trig_lvl = 5'd4;
        3'd3:    trig_lvl = 5'd8;
        3'd4:    trig_lvl = 5'd14;
        default: trig_lvl = `UFIS_FIFO_FULL;
      endcase
    end
  endfunction
  reg [7:0]  efr_q, ier_q, mcr_q, lcr_q, xon1_q, xon2_q, xoff1_q, xoff2_q;
  reg [15:0] div_q;
  reg [1:0]  trig_q;
  function [7:0] wl_mask;
    input [1:0] wl;
    begin
      wl_mask = 8'hFF >> (2'd3 - wl);
    end
  endfunction
  function cmp;
    input [7:0] a;
    input [7:0] b;
    input [1:0] wl;
    begin
      cmp = ((a ^ b) & wl_mask(wl)) == 8'h00;
    end
  endfunction
// ****************************************
// APB slave, one wait state
// ****************************************
  reg        rdy_q;
  reg        cts_flag_q, xoff_flag_q, wake_q, dcts_q;
  reg        fc_halt_q;
  wire       acc    = psel & penable;
  wire       mapped = (paddr[1:0] == 2'b00) && (paddr <= `UFIS_OFS_TRIG);
  wire       wr_en  = acc & rdy_q & pwrite & mapped & ~bus_isolate;
  wire       rd_en  = acc & rdy_q & ~pwrite & mapped;
  assign pready  = rdy_q;
  assign pslverr = rdy_q & ~mapped;
  wire [7:0] isr_val = {2'b00, cts_flag_q, xoff_flag_q, 3'b000, wake_q};
  reg  [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `UFIS_OFS_EFR:   rd_mux[7:0]  = efr_q;
      `UFIS_OFS_IER:   rd_mux[7:0]  = ier_q;
      `UFIS_OFS_MCR:   rd_mux[7:0]  = mcr_q;
      `UFIS_OFS_LCR:   rd_mux[7:0]  = lcr_q;
      `UFIS_OFS_DIV:   rd_mux[15:0] = div_q;
      `UFIS_OFS_XON1:  rd_mux[7:0]  = xon1_q;
      `UFIS_OFS_XON2:  rd_mux[7:0]  = xon2_q;
      `UFIS_OFS_XOFF1: rd_mux[7:0]  = xoff1_q;
      `UFIS_OFS_XOFF2: rd_mux[7:0]  = xoff2_q;
      `UFIS_OFS_ISR:   rd_mux[7:0]  = isr_val;
      `UFIS_OFS_MSR:   rd_mux[7:0]  = {3'b000, ~cts_n_pin, msr_delta_in, dcts_q};
      `UFIS_OFS_TRIG:  rd_mux[1:0]  = trig_q;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdy_q  <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      rdy_q <= acc & ~rdy_q;
      if (acc & ~rdy_q) begin
        prdata <= rd_mux;
      end
    end
  end
  wire thr_wr = wr_en & (paddr == `UFIS_OFS_THR);
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      xon1_q  <= `UFIS_RST_BYTE;
      xon2_q  <= `UFIS_RST_BYTE;
      xoff1_q <= `UFIS_RST_BYTE;
      xoff2_q <= `UFIS_RST_BYTE;
      efr_q   <= `UFIS_RST_BYTE;
      ier_q   <= `UFIS_RST_BYTE;
      mcr_q   <= `UFIS_RST_BYTE;
      lcr_q   <= `UFIS_RST_BYTE;
      div_q   <= `UFIS_RST_DIV;
      trig_q  <= 2'b00;
    end else if (wr_en) begin
      case (paddr)
        `UFIS_OFS_EFR:   efr_q <= pwdata[7:0];
        // upper enables only with enhanced bit
        `UFIS_OFS_IER:   ier_q <= efr_q[`UFIS_EFR_ENH] ? pwdata[7:0]
                                                       : {ier_q[7:4], pwdata[3:0]};
        `UFIS_OFS_MCR:   mcr_q <= pwdata[7:0];
        `UFIS_OFS_LCR:   lcr_q <= pwdata[7:0];
        `UFIS_OFS_DIV:   div_q <= pwdata[15:0];
        `UFIS_OFS_XON1:  xon1_q <= pwdata[7:0];
        `UFIS_OFS_XON2:  xon2_q <= pwdata[7:0];
        `UFIS_OFS_XOFF1: xoff1_q <= pwdata[7:0];
        `UFIS_OFS_XOFF2: xoff2_q <= pwdata[7:0];
        `UFIS_OFS_TRIG:  trig_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end
// ****************************************
// Hardware flow control
// ****************************************
  wire [2:0] tidx  = {1'b0, trig_q} + 3'd1;
  wire [4:0] t_now = trig_lvl(tidx);
  wire [4:0] t_up  = trig_lvl(tidx + 3'd1);
  wire [4:0] t_dn  = trig_lvl(tidx - 3'd1);
  wire       arts  = efr_q[`UFIS_EFR_ARTS];
  reg        rts_off_q;
  assign rx_trig_int = arts & (rx_fill >= t_now);
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rts_off_q <= 1'b0;
      rts_n_pin <= 1'b1;
    end else begin
      if (rx_fill >= t_up) begin
        rts_off_q <= 1'b1;
      end else if (rx_fill <= t_dn) begin
        rts_off_q <= 1'b0;
      end
      // started by modem control RTS bit
      rts_n_pin <= ~(mcr_q[`UFIS_MCR_RTS] & ~(arts & rts_off_q));
    end
  end
  reg cts_n_d1;
  wire cts_chg  = cts_n_d1 ^ cts_n_pin;
  wire msr_read = rd_en & (paddr == `UFIS_OFS_MSR);
  wire isr_read = rd_en & (paddr == `UFIS_OFS_ISR);
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cts_n_d1   <= 1'b0;
      cts_flag_q <= 1'b0;
      dcts_q     <= 1'b0;
    end else begin
      cts_n_d1 <= cts_n_pin;
      // CTS high sets status; set beats clear
      if (cts_chg & cts_n_pin) begin
        cts_flag_q <= 1'b1;
      end else if (isr_read) begin
        cts_flag_q <= 1'b0;
      end
      if (cts_chg) begin
        dcts_q <= 1'b1;
      end else if (msr_read) begin
        dcts_q <= 1'b0;
      end
    end
  end
  assign tx_hold = (efr_q[`UFIS_EFR_ACTS] & cts_n_pin) | fc_halt_q;
// ****************************************
// Software flow control
// ****************************************
  wire [1:0] wl   = lcr_q[1:0];
  wire       swrx = efr_q[`UFIS_EFR_SWRX];
  wire       dbl  = efr_q[`UFIS_EFR_DBL];
  reg        xoff1_seen_q, xon1_seen_q;
  wire m_xoff1 = cmp(rx_char, xoff1_q, wl);
  wire m_xoff2 = cmp(rx_char, xoff2_q, wl);
  wire m_xon1  = cmp(rx_char, xon1_q, wl);
  wire m_xon2  = cmp(rx_char, xon2_q, wl);
  wire xoff_hit = rx_char_vld & swrx & (dbl ? (xoff1_seen_q & m_xoff2) : m_xoff1);
  wire xon_hit  = rx_char_vld & swrx & fc_halt_q
                & (dbl ? (xon1_seen_q & m_xon2) : m_xon1);
  wire part_hit = rx_char_vld & swrx & dbl & (m_xoff1 | (fc_halt_q & m_xon1));
  wire spec_hit = rx_char_vld & efr_q[`UFIS_EFR_SPEC] & m_xoff2 & ~xoff_hit;
  // drop consumed characters, store until full
  assign rx_store = rx_char_vld & ~xoff_hit & ~xon_hit & ~part_hit
                  & (rx_fill < FIFO_DEPTH[4:0]);
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      xoff1_seen_q <= 1'b0;
      xon1_seen_q  <= 1'b0;
      fc_halt_q    <= 1'b0;
      xoff_flag_q  <= 1'b0;
    end else begin
      if (rx_char_vld) begin
        xoff1_seen_q <= m_xoff1 & ~xoff_hit;
        xon1_seen_q  <= m_xon1 & ~xon_hit;
      end
      if (xoff_hit) begin
        fc_halt_q <= 1'b1;
      end else if (xon_hit) begin
        fc_halt_q <= 1'b0;
      end
      // Xoff flag; set wins over clears
      if (xoff_hit | spec_hit) begin
        xoff_flag_q <= 1'b1;
      end else if (xon_hit | isr_read) begin
        xoff_flag_q <= 1'b0;
      end
    end
  end
  // delay of two characters in 16x ticks
  wire [3:0] bits  = 4'd7 + {2'b00, wl} + {3'b000, lcr_q[`UFIS_LCR_PAR]}
                   + {3'b000, lcr_q[`UFIS_LCR_STOP]};
  wire [9:0] limit = {1'b0, bits, 5'b00000};
  reg  [9:0] dly_q;
  reg        xoff_sent_q, fc_second_q, fc_xon_q;
  wire       axoff = efr_q[`UFIS_EFR_AXOFF];
  wire       over  = rx_fill >= t_now;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dly_q       <= 10'h000;
      xoff_sent_q <= 1'b0;
      tx_fc_req   <= 1'b0;
      tx_fc_char  <= 8'h00;
      fc_second_q <= 1'b0;
      fc_xon_q    <= 1'b0;
    end else begin
      if (!axoff | !over | xoff_sent_q) begin
        dly_q <= 10'h000;
      end else if (baud16_tick && dly_q != limit) begin
        dly_q <= dly_q + 10'h001;
      end
      if (tx_fc_req) begin
        if (tx_fc_ack) begin
          fc_second_q <= dbl & ~fc_second_q;
          tx_fc_req   <= dbl & ~fc_second_q;
          tx_fc_char  <= fc_xon_q ? xon2_q : xoff2_q;
        end
      end else if (axoff & ~xoff_sent_q & (dly_q == limit)) begin
        tx_fc_req   <= 1'b1;
        tx_fc_char  <= xoff1_q;
        fc_xon_q    <= 1'b0;
        xoff_sent_q <= 1'b1;
      end else if (xoff_sent_q & (rx_fill <= t_dn)) begin
        tx_fc_req   <= 1'b1;
        tx_fc_char  <= xon1_q;
        fc_xon_q    <= 1'b1;
        xoff_sent_q <= 1'b0;
      end
    end
  end
// ****************************************
// Infrared encoder and decoder
// ****************************************
  reg [3:0] ir_tx_cnt_q, ir_rx_cnt_q;
  reg       ir_pulse_q, ir_rx_d1, ir_rx_zero_q;
  wire      irmode = mcr_q[`UFIS_MCR_IR];
  wire      ir_in = rxd_pin ^ mcr_q[`UFIS_MCR_IRINV];
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ir_tx_cnt_q  <= 4'h0;
      ir_pulse_q   <= 1'b0;
      ir_rx_cnt_q  <= 4'h0;
      // Held high so ir_in & ~ir_rx_d1 cannot flag a false pulse after reset
      ir_rx_d1     <= 1'b1;
      ir_rx_zero_q <= 1'b0;
    end else begin
      if (tx_bit_start) begin
        ir_pulse_q  <= ~tx_serial;
        ir_tx_cnt_q <= 4'h0;
      end else if (baud16_tick && ir_pulse_q) begin
        ir_tx_cnt_q <= ir_tx_cnt_q + 4'h1;
        if (ir_tx_cnt_q == `UFIS_IR_PULSE - 4'h1) begin
          ir_pulse_q <= 1'b0;
        end
      end
      ir_rx_d1 <= ir_in;
      // Pulse stretched to a full zero bit
      if (ir_in & ~ir_rx_d1) begin
        ir_rx_zero_q <= 1'b1;
        ir_rx_cnt_q  <= 4'h0;
      end else if (baud16_tick && ir_rx_zero_q) begin
        ir_rx_cnt_q <= ir_rx_cnt_q + 4'h1;
        if (ir_rx_cnt_q == `UFIS_BIT_TICKS) begin
          ir_rx_zero_q <= 1'b0;
        end
      end
    end
  end
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txd_pin   <= 1'b1;
      rx_serial <= 1'b1;
    end else begin
      txd_pin   <= irmode ? ir_pulse_q : tx_serial;
      rx_serial <= irmode ? ~ir_rx_zero_q : rxd_pin;
    end
  end
// ****************************************
// Sleep and power isolation
// ****************************************
  reg  rx_d1;
  wire rx_fall   = rx_d1 & ~rxd_pin;
  wire own_pend  = (cts_flag_q & ier_q[`UFIS_IER_CTS])
                 | (xoff_flag_q & ier_q[`UFIS_IER_XOFF]) | rx_trig_int;
  assign irq = own_pend | wake_q;
  wire can_sleep = ier_q[`UFIS_IER_SLEEP] & ~own_pend & ~wake_q & ~core_int_pend
                 & (div_q != 16'h0000) & ~dcts_q & (msr_delta_in == 3'b000)
                 & rxd_pin;
  assign bus_isolate = sleep_q & power_isolate_pin;
  wire wake_ev = rx_fall | cts_chg | (thr_wr & ~bus_isolate);
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_d1   <= 1'b1;
      sleep_q <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      rx_d1 <= rxd_pin;
      if (sleep_q) begin
        if (wake_ev | ~ier_q[`UFIS_IER_SLEEP]) begin
          sleep_q <= 1'b0;
          wake_q  <= wake_ev;
        end
      end else if (can_sleep & ~wake_ev) begin
        sleep_q <= 1'b1;
      end
      if (isr_read & ~(sleep_q & wake_ev)) begin
        wake_q <= 1'b0;
      end
    end
  end
endmodule // ufis_ctrl

// ### src/ufis_regs.vh
// Register offsets, field positions and reset values of the flow/IR/sleep block
`ifndef UFIS_REGS_VH
`define UFIS_REGS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define UFIS_OFS_EFR    8'h00
`define UFIS_OFS_IER    8'h04
`define UFIS_OFS_MCR    8'h08
`define UFIS_OFS_LCR    8'h0C
`define UFIS_OFS_DIV    8'h10
`define UFIS_OFS_XON1   8'h14
`define UFIS_OFS_XON2   8'h18
`define UFIS_OFS_XOFF1  8'h1C
`define UFIS_OFS_XOFF2  8'h20
`define UFIS_OFS_ISR    8'h24
`define UFIS_OFS_MSR    8'h28
`define UFIS_OFS_THR    8'h2C
`define UFIS_OFS_TRIG   8'h30
// ****************************************
// Field positions
// ****************************************
`define UFIS_EFR_SWRX   1
`define UFIS_EFR_DBL    0
`define UFIS_EFR_AXOFF  3
`define UFIS_EFR_ENH    4
`define UFIS_EFR_SPEC   5
`define UFIS_EFR_ARTS   6
`define UFIS_EFR_ACTS   7
`define UFIS_IER_SLEEP  4
`define UFIS_IER_XOFF   5
`define UFIS_IER_CTS    7
`define UFIS_MCR_RTS    1
`define UFIS_MCR_IRINV  2
`define UFIS_MCR_IR     6
`define UFIS_LCR_STOP   2
`define UFIS_LCR_PAR    3
`define UFIS_ISR_WAKE   0
`define UFIS_ISR_XOFF   4
`define UFIS_ISR_CTS    5
// ****************************************
// Reset values and timing counts
// ****************************************
`define UFIS_RST_BYTE   8'h00
`define UFIS_RST_DIV    16'h0000
`define UFIS_IR_PULSE   4'h3
`define UFIS_BIT_TICKS  4'hF
`define UFIS_FIFO_FULL  5'h10
`endif

// ### test/ufis_ctrl_sva.sv
// Port-level assertion checker for the flow/IR/sleep block
`timescale 1ns/1ns
module ufis_ctrl_sva (
  input wire       clk_sys,           // System clock
  input wire       resetn,            // Async reset, active low
  input wire       psel,              // APB select
  input wire       penable,           // APB enable
  input wire       pready,            // APB ready
  input wire       pslverr,           // APB error
  input wire [4:0] rx_fill,           // Receive FIFO fill
  input wire       rx_char_vld,       // Received character strobe
  input wire       rx_store,          // FIFO write strobe
  input wire       tx_fc_ack,         // Flow char taken
  input wire       tx_fc_req,         // Flow char request
  input wire [7:0] tx_fc_char,        // Flow char value
  input wire       rts_n_pin,         // RTS pin
  input wire [3:1] msr_delta_in,      // Modem deltas
  input wire       core_int_pend,     // Core interrupts
  input wire       power_isolate_pin, // Power-save strap
  input wire       sleep_q,           // Sleep state
  input wire       bus_isolate        // Bus isolation
);
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_pready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready) // APB
    else $error("ready not in second access cycle");
  a_pready_pulse: assert property (pready |=> !pready) // APB
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready) // APB
    else $error("error without ready");
  a_iso_follows: assert property (bus_isolate == (sleep_q && power_isolate_pin))
    else $error("isolation not sleep and strap");
  a_store_char: assert property (rx_store |-> rx_char_vld)
    else $error("store without character");
  a_fc_req_held: assert property (tx_fc_req && !tx_fc_ack |=> tx_fc_req)
    else $error("flow request dropped early");
  a_fc_char_stable: assert property (tx_fc_req && !tx_fc_ack |=> $stable(tx_fc_char))
    else $error("flow char changed while pending");
  a_sleep_entry: assert property ($rose(sleep_q) |-> $past(msr_delta_in) == 3'h0
    && !$past(core_int_pend))
    else $error("sleep entered while busy");
  a_rts_off_fill: assert property ($rose(rts_n_pin) |-> $past(rx_fill) >= 5'h04)
    else $error("RTS off below upper level");
endmodule // ufis_ctrl_sva

// ### test/ufis_remote.sv
// Remote UART model: handshake line and serial start bits
`timescale 1ns/1ns
module ufis_remote (
  input  wire clk_sys,   // Bench clock
  input  wire rts_n_pin, // Local RTS; high makes us pause
  input  wire stop_req,  // Bench asks remote to deassert its RTS
  input  wire send_req,  // Bench asks for one start bit
  output reg  cts_n_pin, // Remote RTS into local CTS
  output reg  rxd_pin    // Remote serial line, idles high
);
  reg [4:0] bit_cnt_q;
  initial begin
    cts_n_pin = 1'b0;
    rxd_pin   = 1'b1;
    bit_cnt_q = 5'h00;
  end
  always @(posedge clk_sys) begin
    cts_n_pin <= stop_req;
    if (bit_cnt_q != 5'h00) begin
      bit_cnt_q <= bit_cnt_q - 5'h01;
      rxd_pin   <= (bit_cnt_q == 5'h01);
    end else if (send_req && !rts_n_pin) begin
      // Honour local RTS: no new character while it is off
      bit_cnt_q <= 5'h10;
      rxd_pin   <= 1'b0;
    end
  end
endmodule // ufis_remote

// ### test/uart_flow_ir_sleep_ctrl_bench.sv
// Self-checking bench for the flow/IR/sleep block
`timescale 1ns/1ns
`include "ufis_regs.vh"
module uart_flow_ir_sleep_ctrl_bench;
  reg clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [7:0] paddr = 8'h00, rx_char = 8'h00;
  reg [31:0] pwdata = 32'h0, rdv;
  reg baud16_tick = 1, rx_char_vld = 0, tx_bit_start = 0, tx_serial = 1, tx_fc_ack = 0;
  reg core_int_pend = 0, power_isolate_pin = 0, stop_req = 0, send_req = 0, rerr;
  reg [4:0] rx_fill = 5'h00;
  reg [3:1] msr_delta_in = 3'h0;
  wire pready, pslverr, rx_store, tx_hold, tx_fc_req, txd_pin, rx_serial, rts_n_pin;
  wire cts_n_pin, rxd_pin, irq, rx_trig_int, sleep_q, bus_isolate;
  wire [31:0] prdata;
  wire [7:0] tx_fc_char;
  int n_mismatch = 0, check_count = 0, i, k;
  logic [4:0] fl [5] = '{5'h04, 5'h07, 5'h08, 5'h02, 5'h01};
  always #10 clk_sys = ~clk_sys;
  ufis_ctrl u_ufis_ctrl (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .baud16_tick, .rx_fill, .rx_char_vld, .rx_char, .rx_store,
    .tx_bit_start, .tx_serial, .tx_fc_ack, .tx_hold, .tx_fc_req, .tx_fc_char, .txd_pin,
    .rxd_pin, .rx_serial, .rts_n_pin, .cts_n_pin, .msr_delta_in, .core_int_pend, .irq,
    .rx_trig_int, .power_isolate_pin, .sleep_q, .bus_isolate);
  ufis_remote u_ufis_remote (.clk_sys, .rts_n_pin, .stop_req, .send_req, .cts_n_pin,
    .rxd_pin);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // Setup, access until ready, release at the ready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    chb(pready, 1'b1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv & m, e);
  endtask
  // Strobe is combinational, so look at it inside the valid cycle
  task rxc(input logic [7:0] c, input logic st);
    @(posedge clk_sys);
    rx_char <= c; rx_char_vld <= 1'b1;
    @(negedge clk_sys);
    chb(rx_store, st);
    @(posedge clk_sys);
    rx_char_vld <= 1'b0;
    @(negedge clk_sys);
  endtask
  task nx(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    nx(1);
    chb(rts_n_pin, 1'b1); chb(txd_pin, 1'b1); chb(tx_fc_req, 1'b0); chb(sleep_q, 1'b0);
    for (i = 0; i < 4; i++) begin
      rdm(`UFIS_OFS_XON1 + 8'(4 * i), 32'hFF, 32'h0);
      wr(`UFIS_OFS_XON1 + 8'(4 * i), 32'hA5 + i);
      rdm(`UFIS_OFS_XON1 + 8'(4 * i), 32'hFF, 32'hA5 + i);
    end
    rdm(8'h34, 32'hFFFFFFFF, 32'h0);
    chb(rerr, 1'b1);
    // ****** Auto RTS hysteresis ******
    wr(`UFIS_OFS_EFR, 32'h50); wr(`UFIS_OFS_TRIG, 32'h1);
    wr(`UFIS_OFS_MCR, 32'h02);
    nx(2);
    chb(rts_n_pin, 1'b0);
    for (k = 0; k < 5; k++) begin
      @(posedge clk_sys) rx_fill <= fl[k];
      nx(3);
      chb(rts_n_pin, 5'b01100 >> k);
      chb(rx_trig_int, fl[k] >= 5'h04);
      if (k == 2) rxc(8'h41, 1'b1);
    end
    @(posedge clk_sys) rx_fill <= 5'h00;
    // ****** Auto CTS ******
    wr(`UFIS_OFS_EFR, 32'h10);
    @(posedge clk_sys) stop_req <= 1'b1;
    nx(3);
    chb(tx_hold, 1'b0);
    @(posedge clk_sys) stop_req <= 1'b0;
    wr(`UFIS_OFS_EFR, 32'h90); wr(`UFIS_OFS_IER, 32'h80); rdm(`UFIS_OFS_ISR, 32'h0, 32'h0);
    @(posedge clk_sys) stop_req <= 1'b1;
    nx(3);
    chb(tx_hold, 1'b1);
    chb(irq, 1'b1);
    rdm(`UFIS_OFS_ISR, 32'h20, 32'h20);
    @(posedge clk_sys) stop_req <= 1'b0;
    nx(3);
    chb(tx_hold, 1'b0);
    // ****** Software flow control ******
    wr(`UFIS_OFS_EFR, 32'h12); wr(`UFIS_OFS_IER, 32'h20); wr(`UFIS_OFS_LCR, 32'h3);
    wr(`UFIS_OFS_XOFF1, 32'h13); wr(`UFIS_OFS_XON1, 32'h11); rdm(`UFIS_OFS_ISR, 32'h0, 32'h0);
    rxc(8'h13, 1'b0);
    chb(tx_hold, 1'b1);
    chb(irq, 1'b1);
    rxc(8'h11, 1'b0);
    chb(tx_hold, 1'b0);
    rdm(`UFIS_OFS_ISR, 32'h10, 32'h0);
    wr(`UFIS_OFS_LCR, 32'h0);
    rxc(8'hF3, 1'b0);
    chb(tx_hold, 1'b1);
    rdm(`UFIS_OFS_ISR, 32'h10, 32'h10);
    rxc(8'hF1, 1'b0);
    chb(tx_hold, 1'b0);
    rxc(8'h41, 1'b1);
    // ****** Special character ******
    wr(`UFIS_OFS_EFR, 32'h30); wr(`UFIS_OFS_LCR, 32'h3); wr(`UFIS_OFS_XOFF2, 32'h2A);
    rxc(8'h2A, 1'b1);
    rdm(`UFIS_OFS_ISR, 32'h10, 32'h10);
    // ****** Automatic Xoff and Xon, 8N1 char is 160 ticks ******
    wr(`UFIS_OFS_EFR, 32'h18);
    @(posedge clk_sys) rx_fill <= 5'h04;
    nx(300);
    chb(tx_fc_req, 1'b0);
    for (i = 0; i < 2; i++) begin
      k = 0;
      while (tx_fc_req !== 1'b1 && k < 60) begin
        nx(1);
        k++;
      end
      chb(tx_fc_req, 1'b1);
      chk(32'(tx_fc_char), i ? 32'h11 : 32'h13);
      @(posedge clk_sys) tx_fc_ack <= 1'b1;
      @(posedge clk_sys) tx_fc_ack <= 1'b0;
      nx(1);
      chb(tx_fc_req, 1'b0);
      @(posedge clk_sys) rx_fill <= 5'h02;
      nx(5);
      chb(tx_fc_req, 1'b0);
      @(posedge clk_sys) rx_fill <= 5'h00;
    end
    // ****** Infrared ******
    wr(`UFIS_OFS_EFR, 32'h0); wr(`UFIS_OFS_MCR, 32'h42);
    nx(2);
    chb(txd_pin, 1'b0);
    @(posedge clk_sys) begin
      tx_serial <= 1'b0; tx_bit_start <= 1'b1;
    end
    @(posedge clk_sys) tx_bit_start <= 1'b0;
    k = 0;
    repeat (16) begin
      @(negedge clk_sys);
      k += int'(txd_pin === 1'b1);
    end
    chk(k, 3);
    @(posedge clk_sys) tx_serial <= 1'b1;
    wr(`UFIS_OFS_MCR, 32'h46);
    nx(2);
    chb(rx_serial, 1'b1);
    @(posedge clk_sys) send_req <= 1'b1;
    @(posedge clk_sys) send_req <= 1'b0;
    k = 0;
    repeat (20) begin
      @(negedge clk_sys);
      k += int'(rx_serial === 1'b0);
    end
    chb(k > 0, 1'b1);
    wr(`UFIS_OFS_MCR, 32'h02);
    // ****** Sleep, wake and power isolation ******
    wr(`UFIS_OFS_EFR, 32'h10); wr(`UFIS_OFS_DIV, 32'h0); wr(`UFIS_OFS_IER, 32'h10);
    rdm(`UFIS_OFS_ISR, 32'h0, 32'h0);
    rdm(`UFIS_OFS_MSR, 32'h1, 32'h1);
    nx(10);
    chb(sleep_q, 1'b0);
    wr(`UFIS_OFS_DIV, 32'h1);
    nx(10);
    chb(sleep_q, 1'b1);
    wr(`UFIS_OFS_THR, 32'h55);
    nx(2);
    chb(sleep_q, 1'b0);
    rdm(`UFIS_OFS_ISR, 32'h1, 32'h1);
    rdm(`UFIS_OFS_ISR, 32'h1, 32'h0);
    @(posedge clk_sys) power_isolate_pin <= 1'b1;
    nx(10);
    chb(bus_isolate, 1'b1);
    wr(`UFIS_OFS_IER, 32'h0);
    wr(`UFIS_OFS_THR, 32'h55);
    chb(sleep_q, 1'b1);
    rdm(`UFIS_OFS_IER, 32'h10, 32'h10);
    @(posedge clk_sys) send_req <= 1'b1;
    @(posedge clk_sys) send_req <= 1'b0;
    nx(4);
    chb(sleep_q, 1'b0);
    @(posedge clk_sys) power_isolate_pin <= 1'b0;
    nx(20);
    stop_test;
  end
endmodule // uart_flow_ir_sleep_ctrl_bench
bind ufis_ctrl ufis_ctrl_sva u_ufis_ctrl_sva (.clk_sys, .resetn, .psel, .penable, .pready,
  .pslverr, .rx_fill, .rx_char_vld, .rx_store, .tx_fc_ack, .tx_fc_req, .tx_fc_char,
  .rts_n_pin, .msr_delta_in, .core_int_pend, .power_isolate_pin, .sleep_q, .bus_isolate);
